// file: rtl/tcw_pkg.sv
// Shared constants and types of the timer, compare, capture and wakeup block.
package tcw_pkg;

	localparam int TW  = 16;
	localparam int NT  = 3;
	localparam int NOC = 2;
	localparam int NIC = 2;
	localparam int NWT = 2;
	localparam int NEV = 4;
	localparam int NSYNC = 8;
	localparam int STW = 11;

	// Synchronised input positions.
	localparam int SY_RC   = 0;
	localparam int SY_XLF  = 1;
	localparam int SY_LP   = 2;
	localparam int SY_TPIN = 3;
	localparam int SY_CPIN = 6;

	// Byte offsets of the register map.
	localparam logic [7:0] T_CTRL_OFF   = 8'h00;
	localparam logic [7:0] T_PERIOD_OFF = 8'h04;
	localparam logic [7:0] T_COUNT_OFF  = 8'h08;
	localparam logic [7:0] T_STRIDE     = 8'h10;
	localparam logic [7:0] OC_CTRL_OFF  = 8'h30;
	localparam logic [7:0] OC_CMP_OFF   = 8'h38;
	localparam logic [7:0] IC_CTRL_OFF  = 8'h40;
	localparam logic [7:0] IC_CAP_OFF   = 8'h48;
	localparam logic [7:0] WT_CTRL_OFF  = 8'h50;
	localparam logic [7:0] WT_CNT_OFF   = 8'h54;
	localparam logic [7:0] WT_EV_OFF    = 8'h5C;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h70;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h74;
	localparam logic [7:0] WORD        = 8'h04;

	// Status bit positions.
	localparam int ST_OVF = 0;
	localparam int ST_OC  = 3;
	localparam int ST_IC  = 5;
	localparam int ST_WEV = 7;

	typedef enum logic [1:0] {
		MODE_STOP   = 2'b00,
		MODE_FREE   = 2'b01,
		MODE_PERIOD = 2'b10,
		MODE_UPDOWN = 2'b11
	} tcw_mode_type;

	typedef enum logic [2:0] {
		SRC_SYS = 3'b000,
		SRC_RC  = 3'b001,
		SRC_XLF = 3'b010,
		SRC_LP  = 3'b011,
		SRC_PIN = 3'b100
	} tcw_src_type;

	// Timer control word, lowest field in bit 0.
	typedef struct packed {
		logic         sd;
		tcw_mode_type mode;
		logic [2:0]   psc;
		logic         sync;
		logic         inv;
		tcw_src_type  src;
	} tcw_tctrl_type;

	localparam int CT_W = 11;

	function automatic logic [7:0] tcw_addr(input logic [7:0] base, input int idx, input logic [7:0] stride);
		return base + 8'(idx) * stride;
	endfunction

endpackage

// file: rtl/tcw_timer.sv
// One general-purpose timer with clock select, prescaler, counting modes and sigma-delta output.
`timescale 1ns/100ps
module tcw_timer
	import tcw_pkg::*;
#(
	parameter int PSC_W = 8
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Configuration and results.
	tcw_tmr_if.timer  t
);

	if (PSC_W < 7) begin : g_chk
		$error("Prescaler too narrow for the largest division.");
	end

	typedef struct packed {
		logic             rs;
		logic             prev;
		logic [PSC_W-1:0] psc;
		logic [TW-1:0]    cnt;
		logic             up;
		logic [TW-1:0]    acc;
		logic             sd;
		logic             tick;
		logic             ovf;
	} tcw_tstate_type;

	tcw_tstate_type q;
	tcw_tstate_type d;

	function automatic logic [PSC_W-1:0] psc_mask(input logic [2:0] p);
		return PSC_W'((1 << p) - 1);
	endfunction

	logic lvl;
	logic cur;
	logic edge_s;
	logic tk;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		d.ovf = 1'b0;
		lvl = 1'b0;
		case (t.ctrl.src)
			SRC_RC:  lvl = t.src_lvl[0];
			SRC_XLF: lvl = t.src_lvl[1];
			SRC_LP:  lvl = t.src_lvl[2];
			SRC_PIN: lvl = t.src_lvl[3];
			default: lvl = 1'b0;
		endcase
		d.rs = lvl ^ t.ctrl.inv;
		cur = t.ctrl.sync ? q.rs : d.rs;
		d.prev = cur;
		edge_s = (t.ctrl.src == SRC_SYS) ? 1'b1 : (cur & ~q.prev);
		if (edge_s) begin
			d.psc = q.psc + 1'b1;
		end
		tk = edge_s && ((q.psc & psc_mask(t.ctrl.psc)) == psc_mask(t.ctrl.psc));
		if (t.load) begin
			d.cnt = t.load_val;
			d.up = 1'b1;
		end else if (tk && t.ctrl.mode != MODE_STOP) begin
			d.tick = 1'b1;
			case (t.ctrl.mode)
				MODE_FREE: begin
					d.cnt = q.cnt + 1'b1;
					d.ovf = &q.cnt;
				end
				MODE_PERIOD: begin
					if (q.cnt >= t.period) begin
						d.cnt = '0;
						d.ovf = 1'b1;
					end else begin
						d.cnt = q.cnt + 1'b1;
					end
				end
				default: begin
					if (t.period == '0) begin
						d.cnt = '0;
						d.ovf = 1'b1;
					end else if (q.up) begin
						if (q.cnt >= t.period) begin
							d.up = 1'b0;
							d.cnt = q.cnt - 1'b1;
						end else begin
							d.cnt = q.cnt + 1'b1;
						end
					end else if (q.cnt == '0) begin
						d.up = 1'b1;
						d.ovf = 1'b1;
						d.cnt = q.cnt + 1'b1;
					end else begin
						d.cnt = q.cnt - 1'b1;
					end
				end
			endcase
		end
		if (!t.ctrl.sd) begin
			d.sd = 1'b0;
			d.acc = '0;
		end else if (tk) begin
			{d.sd, d.acc} = {1'b0, q.acc} + {1'b0, t.period};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign t.cnt = q.cnt;
	assign t.tick = q.tick;
	assign t.ovf = q.ovf;
	assign t.sd_out = q.sd;

endmodule

// file: rtl/tcw_tmr_if.sv
// Interface carrying one timer's configuration and results.
`timescale 1ns/100ps
interface tcw_tmr_if;
	import tcw_pkg::*;
	tcw_tctrl_type  ctrl;
	logic [TW-1:0]  period;
	logic [3:0]     src_lvl;
	logic           load;
	logic [TW-1:0]  load_val;
	logic [TW-1:0]  cnt;
	logic           tick;
	logic           ovf;
	logic           sd_out;
	modport timer (input ctrl, period, src_lvl, load, load_val, output cnt, tick, ovf, sd_out);
	modport host  (output ctrl, period, src_lvl, load, load_val, input cnt, tick, ovf, sd_out);
endinterface

// file: rtl/tcw_top.sv
// Timer, output compare, input capture and wakeup timer block behind an APB slave.
// Function
// - Three identical timers with 16-bit counts.
// - Clock from system, oscillators or pin.
// - Optional inversion of the counting clock.
// - Power-of-two prescaler before each counter.
// - Optional resynchronisation stage, bypassable.
// - Four software-selected counting modes.
// - Sigma-delta bit stream on dedicated pin.
// - Two output compare units producing PWM.
// - Two input capture units timestamping transitions.
// - Two wakeup timers, four event registers.
// - Wakeup count match raises an interrupt.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module tcw_top
	import tcw_pkg::*;
(
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Oscillator levels.
	input  wire logic              osc_rc,
	input  wire logic              osc_xlf,
	input  wire logic              osc_lp,
	// Timer clock, capture, PWM and sigma-delta pins.
	input  wire logic [NT-1:0]     tmr_pin,
	input  wire logic [NIC-1:0]    cap_pin,
	output logic      [NOC-1:0]    pwm_out,
	output logic      [NT-1:0]     sd_out,
	// Interrupt.
	output logic                   irq
);

	typedef struct packed {
		logic [NSYNC-1:0]          s1;
		logic [NSYNC-1:0]          s2;
		tcw_tctrl_type [NT-1:0]    ctrl;
		logic [NT-1:0][TW-1:0]     period;
		logic [NOC-1:0][3:0]       occ;
		logic [NOC-1:0][TW-1:0]    ocv;
		logic [NOC-1:0]            oc_out;
		logic [NIC-1:0][3:0]       icc;
		logic [NIC-1:0][TW-1:0]    icv;
		logic [NIC-1:0]            ic_prev;
		logic [NWT-1:0]            wt_en;
		logic [NEV-1:0]            wt_sel;
		logic [NWT-1:0][TW-1:0]    wt_cnt;
		logic                      wt_prev;
		logic [NEV-1:0][TW-1:0]    wev;
		logic [STW-1:0]            stat;
		logic [STW-1:0]            mask;
		logic [31:0]               rdata;
		logic                      err;
	} tcw_state_type;

	tcw_state_type q;
	tcw_state_type d;

	tcw_tmr_if tif[NT] ();

	logic [NT-1:0][TW-1:0] tcnt;
	logic [NT-1:0]         ttick;
	logic [NT-1:0]         tovf;
	logic [NT-1:0]         tload;

	genvar g;
	generate
		for (g = 0; g < NT; g++) begin : g_tmr
			assign tif[g].ctrl = q.ctrl[g];
			assign tif[g].period = q.period[g];
			assign tif[g].src_lvl = {q.s2[SY_TPIN + g], q.s2[SY_LP], q.s2[SY_XLF], q.s2[SY_RC]};
			assign tif[g].load = tload[g];
			assign tif[g].load_val = pwdata[TW-1:0];
			assign tcnt[g] = tif[g].cnt;
			assign ttick[g] = tif[g].tick;
			assign tovf[g] = tif[g].ovf;
			assign sd_out[g] = tif[g].sd_out;
			tcw_timer #(
				.PSC_W   (8)
			) u_tmr (
				.pclk    (pclk),
				.presetn (presetn),
				.t       (tif[g])
			);
		end
	endgenerate

	function automatic logic [1:0] tsel(input logic [1:0] s);
		return (s < 2'(NT)) ? s : 2'b00;
	endfunction

	function automatic logic oc_level(input logic [3:0] c, input logic [TW-1:0] cnt, input logic [TW-1:0] cmp);
		return c[1] ? ((cnt < cmp) ^ c[0]) : c[0];
	endfunction

	function automatic logic cap_edge(input logic [3:0] c, input logic now, input logic was);
		return (c[0] & now & ~was) | (c[1] & ~now & was);
	endfunction

	if (NSYNC != SY_CPIN + NIC) begin : g_chk_sync
		$error("Synchroniser width does not cover every pin.");
	end
	if (SY_CPIN != SY_TPIN + NT) begin : g_chk_tpin
		$error("Timer pin positions overlap the capture pins.");
	end
	if (NT > 3) begin : g_chk_nt
		$error("Timer select field serves at most three timers.");
	end
	if (NWT > 2) begin : g_chk_nwt
		$error("Wakeup select bit serves at most two wakeup timers.");
	end
	if (NOC > 2 || NIC > 2 || NEV > 4) begin : g_chk_map
		$error("Register map holds two units of each kind and four events.");
	end
	if (STW != ST_WEV + NEV) begin : g_chk_stw
		$error("Status width does not match the event layout.");
	end
	if (ST_OC != ST_OVF + NT || ST_IC != ST_OC + NOC || ST_WEV != ST_IC + NIC) begin : g_chk_st
		$error("Status fields overlap.");
	end
	if (CT_W != $bits(tcw_tctrl_type)) begin : g_chk_ct
		$error("Control word width does not match its layout.");
	end

	logic           setup;
	logic           wr;
	logic           hit;
	logic [31:0]    rv;
	logic [STW-1:0] ev;
	logic [STW-1:0] w1c;
	logic [1:0]     ts;
	logic           lvl;
	logic           wtick;
	logic           ok;

	always_comb begin
		d = q;
		setup = psel & ~penable;
		wr = psel & penable & pwrite;
		hit = 1'b0;
		rv = '0;
		ev = '0;
		w1c = '0;
		tload = '0;
		ts = '0;
		lvl = 1'b0;
		ok = 1'b0;
		d.s1 = {cap_pin, tmr_pin, osc_lp, osc_xlf, osc_rc};
		d.s2 = q.s1;

		for (int i = 0; i < NT; i++) begin
			ev[ST_OVF + i] = tovf[i];
		end

		for (int i = 0; i < NOC; i++) begin
			ts = tsel(q.occ[i][3:2]);
			d.oc_out[i] = oc_level(q.occ[i], tcnt[ts], q.ocv[i]);
			ev[ST_OC + i] = q.occ[i][1] & ttick[ts] & (tcnt[ts] == q.ocv[i]);
		end

		for (int i = 0; i < NIC; i++) begin
			ts = tsel(q.icc[i][3:2]);
			lvl = q.s2[SY_CPIN + i];
			d.ic_prev[i] = lvl;
			if (cap_edge(q.icc[i], lvl, q.ic_prev[i])) begin
				d.icv[i] = tcnt[ts];
				ev[ST_IC + i] = 1'b1;
			end
		end

		d.wt_prev = q.s2[SY_LP];
		wtick = q.s2[SY_LP] & ~q.wt_prev;
		for (int w = 0; w < NWT; w++) begin
			if (wtick & q.wt_en[w]) begin
				d.wt_cnt[w] = q.wt_cnt[w] + 1'b1;
			end
		end
		for (int e = 0; e < NEV; e++) begin
			if (wtick & q.wt_en[q.wt_sel[e]] & (d.wt_cnt[q.wt_sel[e]] == q.wev[e])) begin
				ev[ST_WEV + e] = 1'b1;
			end
		end

		for (int i = 0; i < NT; i++) begin
			if (paddr == tcw_addr(T_CTRL_OFF, i, T_STRIDE)) begin
				hit = 1'b1;
				rv = 32'(q.ctrl[i]);
				if (wr) begin
					d.ctrl[i] = tcw_tctrl_type'(pwdata[CT_W-1:0]);
				end
			end else if (paddr == tcw_addr(T_PERIOD_OFF, i, T_STRIDE)) begin
				hit = 1'b1;
				rv = 32'(q.period[i]);
				if (wr) begin
					d.period[i] = pwdata[TW-1:0];
				end
			end else if (paddr == tcw_addr(T_COUNT_OFF, i, T_STRIDE)) begin
				hit = 1'b1;
				rv = 32'(tcnt[i]);
				tload[i] = wr;
			end
		end
		for (int i = 0; i < NOC; i++) begin
			if (paddr == tcw_addr(OC_CTRL_OFF, i, WORD)) begin
				hit = 1'b1;
				rv = 32'(q.occ[i]);
				if (wr) begin
					d.occ[i] = pwdata[3:0];
				end
			end else if (paddr == tcw_addr(OC_CMP_OFF, i, WORD)) begin
				hit = 1'b1;
				rv = 32'(q.ocv[i]);
				if (wr) begin
					d.ocv[i] = pwdata[TW-1:0];
				end
			end
		end
		for (int i = 0; i < NIC; i++) begin
			if (paddr == tcw_addr(IC_CTRL_OFF, i, WORD)) begin
				hit = 1'b1;
				rv = 32'(q.icc[i]);
				if (wr) begin
					d.icc[i] = pwdata[3:0];
				end
			end else if (paddr == tcw_addr(IC_CAP_OFF, i, WORD)) begin
				hit = 1'b1;
				rv = 32'(q.icv[i]);
			end
		end
		if (paddr == WT_CTRL_OFF) begin
			hit = 1'b1;
			rv = 32'({q.wt_sel, q.wt_en});
			if (wr) begin
				{d.wt_sel, d.wt_en} = pwdata[NEV+NWT-1:0];
			end
		end else if (paddr == IRQ_STAT_OFF) begin
			hit = 1'b1;
			rv = 32'(q.stat);
			if (wr) begin
				w1c = pwdata[STW-1:0];
			end
		end else if (paddr == IRQ_MASK_OFF) begin
			hit = 1'b1;
			rv = 32'(q.mask);
			if (wr) begin
				d.mask = pwdata[STW-1:0];
			end
		end
		for (int w = 0; w < NWT; w++) begin
			if (paddr == tcw_addr(WT_CNT_OFF, w, WORD)) begin
				hit = 1'b1;
				rv = 32'(q.wt_cnt[w]);
				if (wr) begin
					d.wt_cnt[w] = pwdata[TW-1:0];
				end
			end
		end
		for (int e = 0; e < NEV; e++) begin
			if (paddr == tcw_addr(WT_EV_OFF, e, WORD)) begin
				hit = 1'b1;
				rv = 32'(q.wev[e]);
				if (wr) begin
					d.wev[e] = pwdata[TW-1:0];
				end
			end
		end

		ok = hit;
		d.stat = (q.stat & ~w1c) | ev;
		if (setup) begin
			d.rdata = ok ? rv : '0;
			d.err = ~ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & q.err;
	assign pwm_out = q.oc_out;
	assign irq = |(q.stat & q.mask);

endmodule

// file: test/tb.sv
// Self-checking testbench of the timer block.
`timescale 1ns/100ps
module tb;
	import tcw_pkg::*;
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, clr, er;
	logic		osc_rc, osc_xlf, osc_lp;
	logic [7:0]	paddr;
	logic [31:0]	pwdata, prdata, rd;
	logic [2:0]	tmr_pin, sd_out;
	logic [1:0]	cap_pin, pwm_out;
	logic [15:0]	c0, dv, pwm_ones, sd_ones, v;
	integer		seed, err_count, cmp_count, i, p;
	tcw_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_rc(osc_rc), .osc_xlf(osc_xlf), .osc_lp(osc_lp), .tmr_pin(tmr_pin), .cap_pin(cap_pin),
		.pwm_out(pwm_out), .sd_out(sd_out), .irq(irq));
	tcw_pins pin_u (.pclk(pclk), .clr(clr), .pwm_out(pwm_out), .sd_out(sd_out), .osc_rc(osc_rc),
		.osc_xlf(osc_xlf), .osc_lp(osc_lp), .tmr_pin(tmr_pin), .pwm_ones(pwm_ones), .sd_ones(sd_ones));
	function automatic logic [15:0] sd_exp(input logic [15:0] val, input int n);
		return 16'((32'(val) * n) >> 16);
	endfunction
	function automatic logic [15:0] src_exp(input int s);
		return (s == 1) ? 16'h0020 : (s == 2) ? 16'h0010 : 16'h0008;
	endfunction
	function automatic logic [15:0] tri_exp(input int k, input int n);
		return 16'(((k % (2 * n)) <= n) ? (k % (2 * n)) : (2 * n - k % (2 * n)));
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task meas(input logic [7:0] a);
		@(posedge pclk);
		apb(1'b0, a, 32'h0);
		c0 = rd[15:0];
		repeat (125) @(posedge pclk);
		apb(1'b0, a, 32'h0);
		dv = rd[15:0] - c0;
	endtask
	task win(input int n);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#100000;
		err_count = err_count + 1;
		print_verdict;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, cap_pin, clr, presetn} = '0;
		{seed, err_count, cmp_count} = {32'd3, 32'd0, 32'd0};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 3; i++) begin
			apb(1'b0, T_COUNT_OFF + T_STRIDE * 8'(i), 32'h0);
			chk(rd, 32'h0);
			v = 16'($random(seed));
			apb(1'b1, {1'b1, v[6:2], 2'b00}, 32'hFFFF);
			chk(er, 1'b1);
			chk(rd, 32'h0);
		end
		p = {$random(seed)} % 5;
		apb(1'b1, T_CTRL_OFF, {22'h0, MODE_FREE, p[2:0], 2'b00, SRC_SYS});
		meas(T_COUNT_OFF);
		chk(dv, 16'(128 >> p));
		apb(1'b1, T_CTRL_OFF, {22'h0, MODE_STOP, 8'h00});
		meas(T_COUNT_OFF);
		chk(dv, 16'h0);
		for (i = 1; i < 5; i++) begin
			v = 16'($random(seed));
			apb(1'b1, T_CTRL_OFF + T_STRIDE, {22'h0, MODE_FREE, 3'h0, v[1:0], 3'(i)});
			meas(T_COUNT_OFF + T_STRIDE);
			chk(dv, src_exp(i));
		end
		apb(1'b1, T_CTRL_OFF, {22'h0, MODE_FREE, 8'h00});
		apb(1'b1, IC_CTRL_OFF, 32'h1);
		apb(1'b1, IRQ_STAT_OFF, 32'h7FF);
		apb(1'b0, IC_CAP_OFF, 32'h0);
		chk(rd, 32'h0);
		cap_pin <= 2'b01;
		repeat (4) @(posedge pclk);
		apb(1'b0, IC_CAP_OFF, 32'h0);
		c0 = rd[15:0];
		apb(1'b0, T_COUNT_OFF, 32'h0);
		chk(16'(rd[15:0] - c0), 16'd6);
		apb(1'b1, IC_CAP_OFF, 32'h5A5A);
		cap_pin <= 2'b00;
		repeat (6) @(posedge pclk);
		apb(1'b0, IC_CAP_OFF, 32'h0);
		chk(rd, {16'h0, c0});
		apb(1'b0, IRQ_STAT_OFF, 32'h0);
		chk(rd[ST_IC], 1'b1);
		apb(1'b1, T_COUNT_OFF, 32'h0);
		apb(1'b1, T_PERIOD_OFF, 32'hF);
		apb(1'b1, T_CTRL_OFF, {22'h0, MODE_PERIOD, 8'h00});
		v = 16'({$random(seed)} % 15 + 1);
		apb(1'b1, OC_CMP_OFF, {16'h0, v});
		apb(1'b1, OC_CTRL_OFF, 32'h2);
		win(160);
		chk(pwm_ones, v * 16'd10);
		apb(1'b0, IRQ_STAT_OFF, 32'h0);
		chk({rd[ST_OVF], rd[ST_OC]}, 2'b11);
		for (i = 0; i < 3; i++) begin
			apb(1'b0, T_COUNT_OFF, 32'h0);
			chk(rd[15:0] <= 16'hF, 1'b1);
		end
		p = {$random(seed)} % 6 + 2;
		apb(1'b1, T_PERIOD_OFF, 32'(p));
		apb(1'b1, T_CTRL_OFF, {22'h0, MODE_UPDOWN, 8'h00});
		apb(1'b1, T_COUNT_OFF, 32'h0);
		for (i = 0; i < 5; i++) begin
			apb(1'b0, T_COUNT_OFF, 32'h0);
			chk(rd, 32'(tri_exp(1 + 3 * i, p)));
		end
		apb(1'b1, OC_CTRL_OFF, 32'h1);
		apb(1'b1, OC_CTRL_OFF + WORD, 32'h1);
		repeat (4) @(posedge pclk);
		chk(pwm_out, 2'b11);
		v = 16'(({$random(seed)} % 255 + 1) << 8);
		apb(1'b1, T_PERIOD_OFF + 8'h20, {16'h0, v});
		apb(1'b1, T_CTRL_OFF + 8'h20, {21'h0, 1'b1, MODE_FREE, 8'h00});
		win(256);
		chk(sd_ones, sd_exp(v, 256));
		chk(sd_out[1:0], 2'b00);
		apb(1'b1, WT_CNT_OFF, 32'h0);
		apb(1'b1, WT_EV_OFF, 32'h2);
		apb(1'b1, WT_CTRL_OFF, 32'h1);
		repeat (60) @(posedge pclk);
		apb(1'b0, IRQ_STAT_OFF, 32'h0);
		chk({rd[ST_WEV+1], rd[ST_WEV], irq}, 3'b010);
		apb(1'b0, WT_CNT_OFF, 32'h0);
		chk(rd >= 32'h2 && rd <= 32'h8, 1'b1);
		apb(1'b1, IRQ_MASK_OFF, 32'h1 << ST_WEV);
		#1 chk(irq, 1'b1);
		apb(1'b1, IRQ_STAT_OFF, 32'h1 << ST_WEV);
		#1 chk(irq, 1'b0);
		repeat (2) @(posedge pclk);
		print_verdict;
	end
endmodule

// file: test/tcw_pins.sv
// Pin-side model: clock sources and lowpass integrators of pwm_out[0] and sd_out[2].
`timescale 1ns/100ps
module tcw_pins (
	// Clock and filter restart.
	input wire logic	pclk,
	input wire logic	clr,
	// Design outputs.
	input wire logic [1:0]	pwm_out,
	input wire logic [2:0]	sd_out,
	// Source levels.
	output logic		osc_rc,
	output logic		osc_xlf,
	output logic		osc_lp,
	output logic [2:0]	tmr_pin,
	// Filtered levels.
	output logic [15:0]	pwm_ones,
	output logic [15:0]	sd_ones
);
	logic [3:0]	ph = 4'h0;
	assign osc_rc = ph[1];
	assign osc_xlf = ph[2];
	assign osc_lp = ph[3];
	assign tmr_pin = {3{ph[3]}};
	always @(posedge pclk) begin
		ph <= ph + 4'h1;
		pwm_ones <= clr ? 16'h0 : pwm_ones + 16'(pwm_out[0]);
		sd_ones <= clr ? 16'h0 : sd_ones + 16'(sd_out[2]);
	end
endmodule

// file: test/tcw_top_asserts.sv
// Port-level assertions of the timer block and their bind.
`timescale 1ns/100ps
module tcw_top_asserts
	import tcw_pkg::*;
(
	// Clock and reset.
	input wire logic		pclk,
	input wire logic		presetn,
	// Register bus.
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [7:0]		paddr,
	input wire logic [31:0]		pwdata,
	input wire logic [31:0]		prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	// Pins.
	input wire logic		osc_rc,
	input wire logic		osc_xlf,
	input wire logic		osc_lp,
	input wire logic [NT-1:0]	tmr_pin,
	input wire logic [NIC-1:0]	cap_pin,
	input wire logic [NOC-1:0]	pwm_out,
	input wire logic [NT-1:0]	sd_out,
	input wire logic		irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_errph; pslverr |-> psel && penable; endproperty
	a_errph: assert property (p_errph) else $error("error outside access");
	property p_unerr; psel && penable && paddr >= 8'h78 |-> pslverr; endproperty
	a_unerr: assert property (p_unerr) else $error("unmapped without error");
	property p_map; psel && penable && (paddr == T_CTRL_OFF || paddr == IRQ_MASK_OFF) |-> !pslverr; endproperty
	a_map: assert property (p_map) else $error("mapped with error");
	property p_unrd; psel && penable && !pwrite && paddr >= 8'h78 |-> prdata == 32'h0; endproperty
	a_unrd: assert property (p_unrd) else $error("unmapped read not zero");
	property p_up; psel && penable |-> prdata[31:16] == 16'h0; endproperty
	a_up: assert property (p_up) else $error("upper read bits set");
	property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_irqf;
		$fell(irq) |-> $past(psel) && $past(penable) && $past(pwrite) && ($past(paddr) >= IRQ_STAT_OFF);
	endproperty
	a_irqf: assert property (p_irqf) else $error("irq fell without write");
endmodule

bind tcw_top tcw_top_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.osc_rc(osc_rc), .osc_xlf(osc_xlf), .osc_lp(osc_lp), .tmr_pin(tmr_pin), .cap_pin(cap_pin),
	.pwm_out(pwm_out), .sd_out(sd_out), .irq(irq));
